/* design/srt_blank_tmr.sv */
/*
  Blanking down-counter: loaded with a length, busy until it runs out.
  Assumes length is at least one cycle.
*/
`timescale 1ns/1ps
module srt_blank_tmr
  import srt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  srt_tmr_if.tmr   t
);
  logic [BLANK_W-1:0] cnt_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= '0;
    end else if (t.load) begin
      cnt_q <= t.len;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - BLANK_W'(1);
    end
  end

  assign t.busy = (cnt_q != '0);
endmodule

/* design/srt_ctrl.sv */
/*
  Synchronous-rectifier trigger/disable and blanking controller: decides the
  gate-drive level from the two current-sense comparator bits and the
  trigger/disable level, with minimum on and off blanking and standby.
  Assumes comparator and trigger inputs arrive asynchronously as logic levels
  and that the blanking settings are quasi-static straps.
*/
`timescale 1ns/1ps
module srt_ctrl
(
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  input  wire logic                    CS_BELOW_ON,
  input  wire logic                    CS_ABOVE_OFF,
  input  wire logic                    TRIG,
  input  wire logic [srt_pkg::CFG_W-1:0] TON_CFG,
  input  wire logic [srt_pkg::CFG_W-1:0] TOFF_CFG,
  output logic                         GATE_DRV,
  output logic                         STANDBY,
  output logic                         DISABLED
);
  import srt_pkg::*;

  logic cs_on_s, cs_off_s, trig_s, trig_prev_q;
  logic trig_rise;
  srt_state_t st_q, st_d;
  logic [STBY_W-1:0] stby_cnt_q;
  logic [WAKE_W-1:0] wake_cnt_q;
  logic trig_seen_q;
  logic gate_q;
  logic [BLANK_W-1:0] ton_len, toff_len;

  srt_tmr_if ton_if ();
  srt_tmr_if toff_if ();

  srt_sync2 u_sync_on  (.CLK(CLK), .RST_N(RST_N), .d(CS_BELOW_ON),  .q(cs_on_s));
  srt_sync2 u_sync_off (.CLK(CLK), .RST_N(RST_N), .d(CS_ABOVE_OFF), .q(cs_off_s));
  srt_sync2 u_sync_trg (.CLK(CLK), .RST_N(RST_N), .d(TRIG),         .q(trig_s));

  srt_blank_tmr u_ton  (.CLK(CLK), .RST_N(RST_N), .t(ton_if));
  srt_blank_tmr u_toff (.CLK(CLK), .RST_N(RST_N), .t(toff_if));

  // linear in setting; no supply term exists in a digital count
  assign ton_len  = BLANK_W'(TON_SLOPE * int'(TON_CFG) + TON_OFFSET_CYC);
  assign toff_len = BLANK_W'(TOFF_SLOPE * int'(TOFF_CFG) + TOFF_OFFSET_CYC);

  // single-cycle edge on the synchronised level, no filter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_s;
    end
  end
  assign trig_rise = trig_s & ~trig_prev_q;

  // standby entry counter: cleared whenever disable drops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stby_cnt_q <= '0;
    end else if (!trig_s) begin
      stby_cnt_q <= '0;
    end else if (stby_cnt_q != STBY_W'(STBY_ENTRY_CYC)) begin
      stby_cnt_q <= stby_cnt_q + STBY_W'(1);
    end
  end

  // wake counter runs only in the wake state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_cnt_q <= '0;
    end else if (st_q == SRT_WAKE) begin
      wake_cnt_q <= wake_cnt_q + WAKE_W'(1);
    end else begin
      wake_cnt_q <= '0;
    end
  end

  // trigger high seen during the off window marks a covered cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      trig_seen_q <= 1'b0;
    end else if (st_q == SRT_ON_BLANK || st_q == SRT_WAIT_CYC) begin
      // a skipped cycle uses up the mark, else every later cycle is lost
      trig_seen_q <= 1'b0;
    end else if (st_q == SRT_ARMED && trig_s && !cs_on_s) begin
      trig_seen_q <= 1'b1;
    end
  end

  always_comb begin
    st_d         = st_q;
    ton_if.load  = 1'b0;
    ton_if.len   = ton_len;
    toff_if.load = 1'b0;
    toff_if.len  = toff_len;
    case (st_q)
      SRT_OFF_BLANK: begin
        // sense turn-on and trigger both ignored until the off blank runs out
        if (!toff_if.busy) begin
          st_d = trig_s ? SRT_WAIT_CYC : SRT_ARMED;
        end
      end
      SRT_ARMED: begin
        if (stby_cnt_q == STBY_W'(STBY_ENTRY_CYC)) begin
          st_d = SRT_STANDBY;
        end else if (cs_on_s && trig_seen_q) begin
          st_d = SRT_WAIT_CYC;
        end else if (cs_on_s) begin
          // trigger blanked, so a disable cannot end this pulse before the min on-time
          st_d        = SRT_ON_BLANK;
          ton_if.load = 1'b1;
        end
      end
      SRT_ON_BLANK: begin
        // trigger and sense turn-off both ignored until the on blank runs out
        if (!ton_if.busy) begin
          if (trig_s) begin
            st_d         = SRT_OFF_BLANK;
            toff_if.load = 1'b1;
          end else begin
            st_d = SRT_ON;
          end
        end
      end
      SRT_ON: begin
        if (trig_rise || trig_s || cs_off_s) begin
          st_d         = SRT_OFF_BLANK;
          toff_if.load = 1'b1;
        end
      end
      SRT_WAIT_CYC: begin
        // hold off until the sense releases, then a fresh cycle
        if (stby_cnt_q == STBY_W'(STBY_ENTRY_CYC)) begin
          st_d = SRT_STANDBY;
        end else if (!trig_s && !cs_on_s) begin
          st_d = SRT_ARMED;
        end
      end
      SRT_STANDBY: begin
        if (!trig_s) begin
          st_d = SRT_WAKE;
        end
      end
      SRT_WAKE: begin
        if (trig_s) begin
          st_d = SRT_STANDBY;
        end else if (wake_cnt_q >= WAKE_W'(WAKE_CYC - 4)) begin
          st_d = SRT_WAIT_CYC;
        end
      end
      default: st_d = SRT_OFF_BLANK;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= SRT_OFF_BLANK;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= (st_d == SRT_ON_BLANK) || (st_d == SRT_ON);
    end
  end

  assign GATE_DRV = gate_q;
  assign STANDBY  = (st_q == SRT_STANDBY);
  assign DISABLED = trig_s;

  // cycle counter for the wake bound
  logic [WAKE_W-1:0] since_low_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      since_low_q <= '0;
    end else if (trig_s || !(st_q == SRT_STANDBY || st_q == SRT_WAKE)) begin
      since_low_q <= '0;
    end else begin
      since_low_q <= since_low_q + WAKE_W'(1);
    end
  end

  property p_trig_off;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ON && trig_rise) |=> !GATE_DRV;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("gate not off after trigger");

  property p_disable_off;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ON && trig_s) |=> (st_q == SRT_OFF_BLANK);
  endproperty
  a_disable_off: assert property (p_disable_off) else $error("disable did not stop gate");

  property p_sense_off;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ON && cs_off_s) |=> (!GATE_DRV && toff_if.busy);
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sense off missed");

  property p_on_blank;
    @(posedge CLK) disable iff (!RST_N)
      $rose(GATE_DRV) |-> GATE_DRV[*8];
  endproperty
  a_on_blank: assert property (p_on_blank) else $error("on blank cut short");

  property p_off_blank;
    @(posedge CLK) disable iff (!RST_N)
      $fell(GATE_DRV) |-> !GATE_DRV[*8];
  endproperty
  a_off_blank: assert property (p_off_blank) else $error("off blank cut short");

  property p_turn_on;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ARMED && cs_on_s && !trig_seen_q && stby_cnt_q != STBY_W'(STBY_ENTRY_CYC))
      |=> (GATE_DRV && ton_if.busy);
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("gate not on at sense");

  property p_standby_off;
    @(posedge CLK) disable iff (!RST_N)
      STANDBY |-> !GATE_DRV;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("gate on in standby");

  property p_stby_clear;
    @(posedge CLK) disable iff (!RST_N)
      (!trig_s) |=> (stby_cnt_q == '0);
  endproperty
  a_stby_clear: assert property (p_stby_clear) else $error("standby count kept");

  property p_wake;
    @(posedge CLK) disable iff (!RST_N)
      since_low_q <= WAKE_W'(WAKE_CYC);
  endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");

  property p_last_pulse;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ON_BLANK && !ton_if.busy && trig_s) |=> !GATE_DRV;
  endproperty
  a_last_pulse: assert property (p_last_pulse) else $error("last pulse too long");

  property p_trig_blanked;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ON_BLANK && ton_if.busy && trig_s) |=> GATE_DRV;
  endproperty
  a_trig_blanked: assert property (p_trig_blanked) else $error("trigger not blanked");

  property p_covered_skip;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ARMED && cs_on_s && trig_seen_q && stby_cnt_q != STBY_W'(STBY_ENTRY_CYC))
      |=> (!GATE_DRV && st_q == SRT_WAIT_CYC);
  endproperty
  a_covered_skip: assert property (p_covered_skip) else $error("covered cycle not skipped");

  property p_seen_clear;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_WAIT_CYC) |=> !trig_seen_q;
  endproperty
  a_seen_clear: assert property (p_seen_clear) else $error("skip mark kept");

  property p_wait_no_gate;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_WAIT_CYC && cs_on_s) |=> !GATE_DRV;
  endproperty
  a_wait_no_gate: assert property (p_wait_no_gate) else $error("gate on while diode conducts");

  property p_standby_entry;
    @(posedge CLK) disable iff (!RST_N)
      (st_q == SRT_ARMED && stby_cnt_q == STBY_W'(STBY_ENTRY_CYC)) |=> STANDBY;
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");

  property p_stby_sat;
    @(posedge CLK) disable iff (!RST_N)
      stby_cnt_q <= STBY_W'(STBY_ENTRY_CYC);
  endproperty
  a_stby_sat: assert property (p_stby_sat) else $error("standby count overran");

  c_cycle:   cover property (@(posedge CLK) disable iff (!RST_N) $rose(GATE_DRV));
  c_trig:    cover property (@(posedge CLK) disable iff (!RST_N) st_q == SRT_ON && trig_rise);
  c_standby: cover property (@(posedge CLK) disable iff (!RST_N) $rose(STANDBY));
  c_wake:    cover property (@(posedge CLK) disable iff (!RST_N) $fell(STANDBY));
  c_skip:    cover property (@(posedge CLK) disable iff (!RST_N) st_q == SRT_WAIT_CYC && trig_seen_q);
endmodule

/* design/srt_sync2.sv */
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes the input is a plain pin level.
*/
`timescale 1ns/1ps
module srt_sync2 (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* include/srt_pkg.sv */
/*
  Package for the synchronous-rectifier trigger and blanking controller: timing
  constants, blanking-configuration widths and the drive state encoding.
  Assumes a 250 MHz clock.
*/
package srt_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // trigger edge to gate off, typical
  localparam int TRIG_OFF_DELAY_PS = 12000;
  localparam int TRIG_OFF_CYC      = (TRIG_OFF_DELAY_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                     (TRIG_OFF_DELAY_PS / CLK_PERIOD_PS);
  // standby entry: disable held high longer than this
  localparam int STBY_ENTRY_US  = 100;
  localparam int STBY_ENTRY_CYC = (STBY_ENTRY_US * 1000000) / CLK_PERIOD_PS;
  // wake-up recovery after disable falls, longest
  localparam int WAKE_NS  = 500;
  localparam int WAKE_CYC = (WAKE_NS * 1000) / CLK_PERIOD_PS;
  // blanking = slope * setting + offset, all in cycles
  localparam int CFG_W    = 12;
  localparam int BLANK_W  = 16;
  localparam int TON_OFFSET_CYC  = 12;
  localparam int TOFF_OFFSET_CYC = 14;
  localparam int TON_SLOPE       = 1;
  localparam int TOFF_SLOPE      = 1;
  localparam int STBY_W = 16;
  localparam int WAKE_W = 8;
  localparam logic [CFG_W-1:0] TON_CFG_RST  = 12'h000;
  localparam logic [CFG_W-1:0] TOFF_CFG_RST = 12'h000;

  typedef enum logic [2:0] {
    SRT_OFF_BLANK = 3'b000,
    SRT_ARMED     = 3'b001,
    SRT_ON_BLANK  = 3'b010,
    SRT_ON        = 3'b011,
    SRT_WAIT_CYC  = 3'b100,
    SRT_STANDBY   = 3'b101,
    SRT_WAKE      = 3'b110
  } srt_state_t;
endpackage

/* include/srt_tmr_if.sv */
/*
  Interface joining the controller to its blanking timers: a load strobe with
  a length, and a running flag back.
  Assumes all users share the controller clock.
*/
`timescale 1ns/1ps
interface srt_tmr_if;
  import srt_pkg::*;
  logic               load;
  logic [BLANK_W-1:0] len;
  logic               busy;
  modport ctrl (output load, output len, input busy);
  modport tmr  (input load, input len, output busy);
endinterface

/* verif/srt_trig_src.sv */
/*
  Primary-side trigger source seen through a pulse transformer: one-cycle
  needle pulses on command, or a held disable level.
  Assumes the bench commands it just after the rising clock edge.
*/
`timescale 1ns/1ps
module srt_trig_src (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic fire,
  input  wire logic hold,
  output logic      TRIG
);
  logic needle_q;
  // coupling cap makes a needle, so the line falls back even if fire stays up
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      needle_q <= 1'b0;
    end else begin
      needle_q <= fire & ~needle_q;
    end
  end
  // bench fires before it raises sense, so the edge leads the reversal
  assign TRIG = needle_q | hold;
endmodule

/* verif/sync_rectifier_trigger_blanking_ctrl_test.sv */
/*
  Self-checking bench for the trigger and blanking controller: table of
  blanking settings, then trigger, disable, standby and wake cases.
  Assumes the srt_pkg constants and a 250 MHz clock.
*/
`timescale 1ns/1ps
module sync_rectifier_trigger_blanking_ctrl_test;
  import srt_pkg::*;
  typedef struct {
    logic [CFG_W-1:0] ton;
    logic [CFG_W-1:0] toff;
    int               on_len;
    int               off_len;
  } srt_row_t;
  logic             clk      = 1'b0;
  logic             rst_n    = 1'b0;
  logic             cs_on    = 1'b0;
  logic             cs_off   = 1'b0;
  logic             fire     = 1'b0;
  logic             hold     = 1'b0;
  logic [CFG_W-1:0] ton_cfg  = 12'h000;
  logic [CFG_W-1:0] toff_cfg = 12'h000;
  logic             trig;
  logic             gate;
  logic             stby;
  logic             dis;
  int               miscompares = 0;
  int               n_compared  = 0;
  int               n;
  srt_row_t rows [4] = '{'{12'h000, 12'h000, 12, 14}, '{12'h005, 12'h00A, 17, 24},
                         '{12'h040, 12'h001, 76, 15}, '{12'h0FF, 12'h0FF, 267, 269}};

  always #2 clk = ~clk;

  srt_ctrl u_dut (
    .CLK          (clk),
    .RST_N        (rst_n),
    .CS_BELOW_ON  (cs_on),
    .CS_ABOVE_OFF (cs_off),
    .TRIG         (trig),
    .TON_CFG      (ton_cfg),
    .TOFF_CFG     (toff_cfg),
    .GATE_DRV     (gate),
    .STANDBY      (stby),
    .DISABLED     (dis)
  );

  srt_trig_src u_trig (
    .CLK   (clk),
    .RST_N (rst_n),
    .fire  (fire),
    .hold  (hold),
    .TRIG  (trig)
  );

  task automatic check(input logic seen, input logic exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // bounded wait; sampled right after the edge, so pre-update values are seen
  task automatic wait_gate(input logic lvl, input int lim, output int k);
    k = 0;
    while (gate !== lvl && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic do_reset(input logic [CFG_W-1:0] on_c, input logic [CFG_W-1:0] off_c);
    @(posedge clk);
    rst_n    <= 1'b0;
    cs_on    <= 1'b0;
    cs_off   <= 1'b0;
    ton_cfg  <= on_c;
    toff_cfg <= off_c;
    repeat (8) @(posedge clk);
    check(gate | stby | dis, 1'b0, "outputs low in reset");
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
  endtask

  task automatic run_row(input srt_row_t r);
    do_reset(r.ton, r.toff);
    cs_on <= 1'b1;
    wait_gate(1'b1, 20, n);
    check(n <= 6, 1'b1, "gate on latency");
    cs_on  <= 1'b0;
    cs_off <= 1'b1;
    wait_gate(1'b0, 5000, n);
    check(n >= r.on_len && n <= r.on_len + 4, 1'b1, "min on-time");
    cs_off <= 1'b0;
    cs_on  <= 1'b1;
    wait_gate(1'b1, 5000, n);
    check(n >= r.off_len && n <= r.off_len + 6, 1'b1, "min off-time");
    cs_on <= 1'b0;
    $display("row done: ton %0h toff %0h", r.ton, r.toff);
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    // longest path is about 43000 cycles
    #300000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    do_reset(12'h0FF, 12'h000);
    cs_on <= 1'b1;
    wait_gate(1'b1, 20, n);
    cs_on <= 1'b0;
    fire  <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (100) @(posedge clk);
    check(gate, 1'b1, "needle in on-blank ignored");
    repeat (200) @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_gate(1'b0, 8, n);
    check(n <= TRIG_OFF_CYC + 1, 1'b1, "needle turns gate off");
    $display("trigger test done");
    hold <= 1'b1;
    repeat (4) @(posedge clk);
    check(dis, 1'b1, "disable level seen");
    check(gate, 1'b0, "gate off while disabled");
    repeat (15000) @(posedge clk);
    hold <= 1'b0;
    repeat (10) @(posedge clk);
    hold <= 1'b1;
    repeat (15000) @(posedge clk);
    check(stby, 1'b0, "standby count cleared");
    repeat (11000) @(posedge clk);
    check(stby, 1'b1, "standby entered");
    check(gate, 1'b0, "gate off in standby");
    cs_on <= 1'b1;
    hold  <= 1'b0;
    n = 0;
    while (stby !== 1'b0 && n < 140) begin
      @(posedge clk);
      n++;
    end
    check(n <= 128, 1'b1, "wake within 500 ns");
    repeat (200) @(posedge clk);
    check(gate, 1'b0, "no turn-on while diode conducts");
    cs_on <= 1'b0;
    repeat (20) @(posedge clk);
    cs_on <= 1'b1;
    wait_gate(1'b1, 20, n);
    check(n <= 6, 1'b1, "turn-on on next cycle");
    // disable inside min on-time: last pulse runs out the min on-time only
    hold <= 1'b1;
    repeat (100) @(posedge clk);
    check(gate, 1'b1, "disable blanked in min on-time");
    wait_gate(1'b0, 300, n);
    check(n + 100 >= 267 && n + 100 <= 269, 1'b1, "last pulse is min on-time");
    hold  <= 1'b0;
    cs_on <= 1'b0;
    repeat (30) @(posedge clk);
    cs_on <= 1'b1;
    wait_gate(1'b1, 20, n);
    repeat (300) @(posedge clk);
    hold <= 1'b1;
    wait_gate(1'b0, 8, n);
    check(n <= TRIG_OFF_CYC + 1, 1'b1, "disable stops gate at once");
    hold  <= 1'b0;
    cs_on <= 1'b0;
    repeat (40) @(posedge clk);
    // needle while drain is positive marks the coming cycle as covered
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
    cs_on <= 1'b1;
    repeat (20) @(posedge clk);
    check(gate, 1'b0, "covered cycle skipped");
    cs_on <= 1'b0;
    repeat (20) @(posedge clk);
    cs_on <= 1'b1;
    wait_gate(1'b1, 20, n);
    check(n <= 6, 1'b1, "next cycle after skip");
    $display("disable and standby test done");
    finish_test();
  end
endmodule
